/* File: hdl/bhsp_pkg.sv */
// Constants, pin bundle and state encoding for the byte host shadow port.
// Assumes a single system clock and an internal 32-bit register space of 64 words.
package bhsp_pkg;

	// ****************************************************************
	// Address layout
	// ****************************************************************
	localparam int REG_COUNT = 64;
	localparam int HOST_SPACE_BYTES = 256;
	localparam int ADDR_UPDATE_BIT = 8;
	localparam int ADDR_INDEX_HI = 7;
	localparam int ADDR_INDEX_LO = 2;
	localparam logic [8:0] ADDR_UPDATE_WEIGHT = 9'h100;

	// Internal indices served by the queue transfer registers.
	localparam logic [5:0] QUEUE_TX_INDEX = 6'h20;
	localparam logic [5:0] QUEUE_RX_INDEX = 6'h21;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] SHADOW_RESET = 32'h0000_0000;
	localparam logic [5:0] INDEX_RESET = 6'h00;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic select_n;
		logic read_n;
		logic write_n;
		logic [8:0] addr;
		logic [7:0] data;
	} bhsp_host_pins_t;

	localparam bhsp_host_pins_t PINS_IDLE = '{select_n: 1'b1, read_n: 1'b1, write_n: 1'b1,
		addr: 9'h000, data: 8'h00};

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_WRITE = 2'h2
	} bhsp_state_t;

	// Byte 0 is the most significant byte of a quadlet.
	function automatic logic [31:0] bhsp_lane_mask(input logic [1:0] lane);
		bhsp_lane_mask = 32'hFF00_0000 >> {lane, 3'h0};
	endfunction

	function automatic logic [7:0] bhsp_pick(input logic [31:0] word, input logic [1:0] lane);
		logic [31:0] shifted;
		shifted = word << {lane, 3'h0};
		bhsp_pick = shifted[31:24];
	endfunction

	function automatic logic [31:0] bhsp_merge(input logic [31:0] word, input logic [1:0] lane,
		input logic [7:0] value);
		logic [31:0] placed;
		placed = {value, 24'h000000} >> {lane, 3'h0};
		bhsp_merge = (word & ~bhsp_lane_mask(lane)) | placed;
	endfunction

endpackage

/* File: hdl/bhsp_queue_xfer.sv */
// Transfer registers between the host port and the packet queues.
// Assumes the queues use valid/ready handshakes on clk_sys.
`timescale 1ns/100ps

module bhsp_queue_xfer (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic push_valid,
	input wire logic [31:0] push_data,
	input wire logic pop,
	output logic [31:0] rx_word,
	output logic tx_q_valid,
	output logic [31:0] tx_q_data,
	input wire logic tx_q_ready,
	input wire logic rx_q_valid,
	input wire logic [31:0] rx_q_data,
	output logic rx_q_ready
);

	logic tx_full_reg;
	logic [31:0] tx_word_reg;
	logic rx_full_reg;
	logic rx_full_next;
	logic [31:0] rx_word_reg;
	logic rx_ready_reg;
	logic rx_take;

	// A new host word wins over a drain in the same cycle, so it is never lost.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_full_reg <= 1'b0;
			tx_word_reg <= bhsp_pkg::SHADOW_RESET;
		end else if (push_valid) begin
			tx_full_reg <= 1'b1;
			tx_word_reg <= push_data;
		end else if (tx_q_ready) begin
			tx_full_reg <= 1'b0;
		end
	end

	// The receive side prefetches the queue head as soon as the register is free.
	assign rx_take = rx_q_valid & rx_ready_reg;
	always_comb begin
		rx_full_next = rx_full_reg;
		if (rx_take) begin
			rx_full_next = 1'b1;
		end else if (pop) begin
			rx_full_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_full_reg <= 1'b0;
			rx_ready_reg <= 1'b0;
			rx_word_reg <= bhsp_pkg::SHADOW_RESET;
		end else begin
			rx_full_reg <= rx_full_next;
			rx_ready_reg <= ~rx_full_next & ~rx_take;
			if (rx_take) begin
				rx_word_reg <= rx_q_data;
			end
		end
	end

	assign tx_q_valid = tx_full_reg;
	assign tx_q_data = tx_word_reg;
	assign rx_q_ready = rx_ready_reg;
	assign rx_word = rx_word_reg;

endmodule

/* File: hdl/byte_host_shadow_port.sv */
// Byte-wide host port with read and write shadow registers onto a 32-bit register space.
// Assumes the register file answers reg_rd_data in the cycle reg_rd_strobe is high.
`timescale 1ns/100ps

// Notes on behaviour
// - Sixty-four quadlet registers appear to the host as 256 bytes.
// - Every internal register access is a whole 32-bit word.
// - Address bits 1:0 pick the read shadow byte combinationally.
// - Read with update bit copies the addressed register into the read shadow.
// - Update bit weighs 0x100 in the host byte address.
// - Shadow bytes may be read in any order, any number of times.
// - Each write changes exactly one write shadow byte.
// - Write with update bit stores the byte, then commits the whole word.
// - Bytes not rewritten keep their earlier value at commit.
// - Queues are reached only through transfer registers moved by internal logic.
// - Select, read and write all low means a write cycle.
// - Without update bit, index bits are ignored and nothing is copied.
// - Host select and strobes are resampled into the system clock.
module byte_host_shadow_port (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic host_select_n,
	input wire logic host_read_n,
	input wire logic host_write_n,
	input wire logic [8:0] host_addr,
	input wire logic [7:0] host_byte_in,
	output logic [7:0] host_byte_out,
	output logic host_byte_oe,
	output logic reg_rd_strobe,
	output logic [5:0] reg_rd_index,
	input wire logic [31:0] reg_rd_data,
	output logic reg_wr_strobe,
	output logic [5:0] reg_wr_index,
	output logic [31:0] reg_wr_data,
	output logic tx_q_valid,
	output logic [31:0] tx_q_data,
	input wire logic tx_q_ready,
	input wire logic rx_q_valid,
	input wire logic [31:0] rx_q_data,
	output logic rx_q_ready
);

	// ****************************************************************
	// Pin resampling
	// ****************************************************************
	bhsp_pkg::bhsp_host_pins_t pins_raw;
	bhsp_pkg::bhsp_host_pins_t pin_s1_reg;
	bhsp_pkg::bhsp_host_pins_t pin_s2_reg;
	bhsp_pkg::bhsp_host_pins_t pin_s3_reg;
	bhsp_pkg::bhsp_host_pins_t pin_filt_reg;
	logic [19:0] pin_agree;

	assign pins_raw = {host_select_n, host_read_n, host_write_n, host_addr, host_byte_in};

	// Three stages; a bit is taken only once stages two and three agree.
	always_ff @(posedge clk_sys) begin
		pin_s1_reg <= pins_raw;
		pin_s2_reg <= pin_s1_reg;
		pin_s3_reg <= pin_s2_reg;
	end

	assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pin_filt_reg <= bhsp_pkg::PINS_IDLE;
		end else begin
			pin_filt_reg <= (pin_s2_reg & pin_agree) | (pin_filt_reg & ~pin_agree);
		end
	end

	// ****************************************************************
	// Access decode
	// ****************************************************************
	bhsp_pkg::bhsp_state_t state_reg;
	logic access_write;
	logic access_read;
	logic access_end;
	logic start_write;
	logic start_read;
	logic update_bit;
	logic [1:0] lane;
	logic [5:0] index;

	// Write wins when both strobes are low, which suits hosts with one direction line.
	assign access_write = ~pin_filt_reg.select_n & ~pin_filt_reg.write_n;
	assign access_read = ~pin_filt_reg.select_n & ~pin_filt_reg.read_n & pin_filt_reg.write_n;
	assign access_end = pin_filt_reg.select_n | (pin_filt_reg.read_n & pin_filt_reg.write_n);
	assign start_write = (state_reg == bhsp_pkg::ST_IDLE) & access_write;
	assign start_read = (state_reg == bhsp_pkg::ST_IDLE) & access_read;
	assign update_bit = pin_filt_reg.addr[bhsp_pkg::ADDR_UPDATE_BIT];
	assign lane = pin_filt_reg.addr[1:0];
	assign index = pin_filt_reg.addr[bhsp_pkg::ADDR_INDEX_HI:bhsp_pkg::ADDR_INDEX_LO];

	// One access per strobe; a long read stays in one state while byte select moves.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= bhsp_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				bhsp_pkg::ST_IDLE: begin
					if (access_write) begin
						state_reg <= bhsp_pkg::ST_WRITE;
					end else if (access_read) begin
						state_reg <= bhsp_pkg::ST_READ;
					end
				end
				bhsp_pkg::ST_READ, bhsp_pkg::ST_WRITE: begin
					if (access_end) begin
						state_reg <= bhsp_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= bhsp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Write shadow and commit
	// ****************************************************************
	logic [31:0] wr_shadow_reg;
	logic [31:0] wr_shadow_next;
	logic push_valid;
	logic reg_wr_strobe_reg;
	logic [5:0] reg_wr_index_reg;
	logic [31:0] reg_wr_data_reg;

	assign wr_shadow_next = bhsp_pkg::bhsp_merge(wr_shadow_reg, lane, pin_filt_reg.data);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_shadow_reg <= bhsp_pkg::SHADOW_RESET;
		end else if (start_write) begin
			wr_shadow_reg <= wr_shadow_next;
		end
	end

	// The commit uses the merged word, so the new byte lands in the same tick.
	assign push_valid = start_write & update_bit & (index == bhsp_pkg::QUEUE_TX_INDEX);
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_wr_strobe_reg <= 1'b0;
			reg_wr_index_reg <= bhsp_pkg::INDEX_RESET;
			reg_wr_data_reg <= bhsp_pkg::SHADOW_RESET;
		end else begin
			reg_wr_strobe_reg <= start_write & update_bit & (index != bhsp_pkg::QUEUE_TX_INDEX);
			if (start_write & update_bit) begin
				reg_wr_index_reg <= index;
				reg_wr_data_reg <= wr_shadow_next;
			end
		end
	end

	// ****************************************************************
	// Read shadow
	// ****************************************************************
	logic [31:0] rd_shadow_reg;
	logic rd_strobe_reg;
	logic rd_queue_reg;
	logic [5:0] rd_index_reg;
	logic [31:0] rx_word;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_strobe_reg <= 1'b0;
			rd_queue_reg <= 1'b0;
			rd_index_reg <= bhsp_pkg::INDEX_RESET;
		end else begin
			rd_strobe_reg <= start_read & update_bit & (index != bhsp_pkg::QUEUE_RX_INDEX);
			rd_queue_reg <= start_read & update_bit & (index == bhsp_pkg::QUEUE_RX_INDEX);
			if (start_read & update_bit) begin
				rd_index_reg <= index;
			end
		end
	end

	// The snapshot only changes two cycles after a read with update starts; plain reads leave it alone.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_shadow_reg <= bhsp_pkg::SHADOW_RESET;
		end else if (rd_strobe_reg) begin
			rd_shadow_reg <= reg_rd_data;
		end else if (rd_queue_reg) begin
			rd_shadow_reg <= rx_word;
		end
	end

	// ****************************************************************
	// Queue transfer registers
	// ****************************************************************
	bhsp_queue_xfer u_queue_xfer (
		.clk_sys(clk_sys),
		.srst(srst),
		.push_valid(push_valid),
		.push_data(wr_shadow_next),
		.pop(rd_queue_reg),
		.rx_word(rx_word),
		.tx_q_valid(tx_q_valid),
		.tx_q_data(tx_q_data),
		.tx_q_ready(tx_q_ready),
		.rx_q_valid(rx_q_valid),
		.rx_q_data(rx_q_data),
		.rx_q_ready(rx_q_ready)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Byte select and drive window follow the raw pins, so a host can step lanes at bus speed.
	assign host_byte_out = bhsp_pkg::bhsp_pick(rd_shadow_reg, host_addr[1:0]);
	assign host_byte_oe = ~host_select_n & ~host_read_n & host_write_n;
	assign reg_rd_strobe = rd_strobe_reg;
	assign reg_rd_index = rd_index_reg;
	assign reg_wr_strobe = reg_wr_strobe_reg;
	assign reg_wr_index = reg_wr_index_reg;
	assign reg_wr_data = reg_wr_data_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb_sys @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence seq_read_update;
		start_read && update_bit && (index != bhsp_pkg::QUEUE_RX_INDEX);
	endsequence

	sequence seq_snapshot;
		rd_strobe_reg ##1 (rd_shadow_reg == $past(reg_rd_data));
	endsequence

	chk_write_one_byte: assert property (start_write |=>
		((wr_shadow_reg ^ $past(wr_shadow_reg)) & ~bhsp_pkg::bhsp_lane_mask($past(lane))) == 32'h0000_0000)
		else $error("write touched more than one shadow byte");
	chk_write_byte_value: assert property (start_write |=>
		bhsp_pkg::bhsp_pick(wr_shadow_reg, $past(lane)) == $past(pin_filt_reg.data))
		else $error("written shadow byte does not hold bus value");
	chk_commit_word: assert property (start_write && update_bit && (index != bhsp_pkg::QUEUE_TX_INDEX) |=>
		reg_wr_strobe_reg && (reg_wr_data_reg == wr_shadow_reg) && (reg_wr_index_reg == $past(index)))
		else $error("commit word or index wrong");
	chk_no_update_quiet: assert property ((start_write || start_read) && !update_bit |=>
		!reg_wr_strobe_reg && !rd_strobe_reg && !rd_queue_reg && $stable(rd_shadow_reg))
		else $error("access without update bit moved data");
	chk_read_snapshot: assert property (seq_read_update |=> seq_snapshot)
		else $error("read shadow did not take register value");
	chk_shadow_hold: assert property (!rd_strobe_reg && !rd_queue_reg |=> $stable(rd_shadow_reg))
		else $error("read shadow changed without update");
	chk_write_priority: assert property ((state_reg == bhsp_pkg::ST_IDLE) && !pin_filt_reg.select_n &&
		!pin_filt_reg.write_n |=>
		(state_reg == bhsp_pkg::ST_WRITE))
		else $error("write strobe did not start a write cycle");
	chk_read_extended: assert property ((state_reg == bhsp_pkg::ST_READ) && !access_end |=>
		(state_reg == bhsp_pkg::ST_READ) && !rd_strobe_reg)
		else $error("extended read restarted or left early");
	chk_sync_take: assert property ((pin_s2_reg == pin_s3_reg) |=> (pin_filt_reg == $past(pin_s2_reg)))
		else $error("agreed pin value not taken");
	chk_reset_clear: assert property (disable iff (1'b0) srst |=>
		(wr_shadow_reg == 32'h0000_0000) && (rd_shadow_reg == 32'h0000_0000) && (state_reg == bhsp_pkg::ST_IDLE))
		else $error("reset left shadow or state dirty");

endmodule

/* File: verification/bhsp_far_model.sv */
// Register file and queue ends that sit behind the byte host shadow port.
// Assumes one clock, a synchronous active-high reset and one-cycle strobes from the port.
`timescale 1ns/100ps

module bhsp_far_model #(
	parameter logic [31:0] RX_BASE = 32'h0000_0000
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic reg_rd_strobe,
	input wire logic [5:0] reg_rd_index,
	output logic [31:0] reg_rd_data,
	input wire logic reg_wr_strobe,
	input wire logic [5:0] reg_wr_index,
	input wire logic [31:0] reg_wr_data,
	input wire logic tx_q_valid,
	input wire logic [31:0] tx_q_data,
	output logic tx_q_ready,
	output logic [31:0] tx_last,
	output int tx_count,
	output logic rx_q_valid,
	output logic [31:0] rx_q_data,
	input wire logic rx_q_ready
);
	logic [31:0] mem [64];
	logic [1:0] pace_reg;
	int rx_count;

	// ****************************************************************
	// Register file
	// ****************************************************************
	// Whole words only; outside the strobe cycle the bus shows the inverse, so a late sample is caught.
	always_comb reg_rd_data = reg_rd_strobe ? mem[reg_rd_index] : ~mem[reg_rd_index];
	// Commits land as whole words; the file has no byte enables.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < 64; i++) mem[i] <= 32'h0000_0000;
		end else if (reg_wr_strobe) begin
			mem[reg_wr_index] <= reg_wr_data;
		end
	end

	// ****************************************************************
	// Queue ends
	// ****************************************************************
	// The transmit sink stalls two cycles in four, so the transfer register must hold its word.
	always_comb tx_q_ready = pace_reg[1];
	always_comb rx_q_valid = ~srst;
	// A counting source keeps the expected receive words easy to predict.
	always_comb rx_q_data = srst ? ~RX_BASE : RX_BASE + 32'(rx_count);
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pace_reg <= 2'h0;
			tx_count <= 0;
			tx_last <= 32'h0000_0000;
			rx_count <= 0;
		end else begin
			pace_reg <= pace_reg + 2'h1;
			if (tx_q_valid && tx_q_ready) begin
				tx_last <= tx_q_data;
				tx_count <= tx_count + 1;
			end
			if (rx_q_valid && rx_q_ready) rx_count <= rx_count + 1;
		end
	end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the byte host shadow port with random host traffic.
// Assumes the far model in bhsp_far_model.sv and the design files under hdl/.
`timescale 1ns/100ps

module testbench;
	localparam logic [31:0] RX_BASE = 32'hA5C3_0000;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic host_select_n = 1'b1;
	logic host_read_n = 1'b1;
	logic host_write_n = 1'b1;
	logic [8:0] host_addr = 9'h000;
	logic [7:0] host_byte_in = 8'h00;
	logic [7:0] host_byte_out;
	logic host_byte_oe, reg_rd_strobe, reg_wr_strobe, tx_q_valid, tx_q_ready, rx_q_valid, rx_q_ready;
	logic [5:0] reg_rd_index, reg_wr_index, seen_idx, seen_rd_idx;
	logic [31:0] reg_rd_data, reg_wr_data, tx_q_data, rx_q_data, tx_last, seen_data;
	logic [31:0] wshadow = 32'h0000_0000;
	logic [31:0] rshadow = 32'h0000_0000;
	int tx_count;
	int n_errors = 0;
	int checked = 0;
	int n_commit = 0;
	int n_rdreq = 0;

	// ****************************************************************
	// Clock, design and far side
	// ****************************************************************
	always #4 clk_sys = ~clk_sys;
	byte_host_shadow_port uut (.clk_sys(clk_sys), .srst(srst), .host_select_n(host_select_n),
		.host_read_n(host_read_n), .host_write_n(host_write_n), .host_addr(host_addr),
		.host_byte_in(host_byte_in), .host_byte_out(host_byte_out), .host_byte_oe(host_byte_oe),
		.reg_rd_strobe(reg_rd_strobe), .reg_rd_index(reg_rd_index), .reg_rd_data(reg_rd_data),
		.reg_wr_strobe(reg_wr_strobe), .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data),
		.tx_q_valid(tx_q_valid), .tx_q_data(tx_q_data), .tx_q_ready(tx_q_ready),
		.rx_q_valid(rx_q_valid), .rx_q_data(rx_q_data), .rx_q_ready(rx_q_ready));
	bhsp_far_model #(.RX_BASE(RX_BASE)) far (.clk_sys(clk_sys), .srst(srst), .reg_rd_strobe(reg_rd_strobe),
		.reg_rd_index(reg_rd_index), .reg_rd_data(reg_rd_data), .reg_wr_strobe(reg_wr_strobe),
		.reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data), .tx_q_valid(tx_q_valid),
		.tx_q_data(tx_q_data), .tx_q_ready(tx_q_ready), .tx_last(tx_last), .tx_count(tx_count),
		.rx_q_valid(rx_q_valid), .rx_q_data(rx_q_data), .rx_q_ready(rx_q_ready));

	// Every commit and register read request is logged so that stray or missing ones show up in the counts.
	always @(posedge clk_sys) begin
		if (reg_wr_strobe === 1'b1) begin
			n_commit <= n_commit + 1;
			seen_idx <= reg_wr_index;
			seen_data <= reg_wr_data;
		end
		if (reg_rd_strobe === 1'b1) begin
			n_rdreq <= n_rdreq + 1;
			seen_rd_idx <= reg_rd_index;
		end
	end

	// ****************************************************************
	// Expectation helpers and checking
	// ****************************************************************
	// Lane 0 is the most significant byte.
	function automatic logic [7:0] lane_of(input logic [31:0] w, input logic [1:0] l);
		logic [31:0] s;
		s = w >> (8 * (3 - l));
		lane_of = s[7:0];
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] w, input logic [1:0] l, input logic [7:0] v);
		merge = (w & ~(32'hFF00_0000 >> (8 * l))) | ({v, 24'h00_0000} >> (8 * l));
	endfunction
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// ****************************************************************
	// Host bus cycles
	// ****************************************************************
	// Select and strobe fall in a random order, three cycles apart, so the later edge must start it.
	task automatic start(input logic wr, input logic both, input logic [8:0] a, input logic [7:0] d);
		logic sel_first;
		sel_first = 1'($urandom_range(1));
		@(posedge clk_sys);
		host_addr <= a;
		host_byte_in <= d;
		host_select_n <= ~sel_first;
		if (!sel_first) begin
			host_write_n <= ~wr;
			host_read_n <= wr & ~both;
		end
		repeat (3) @(posedge clk_sys);
		host_select_n <= 1'b0;
		host_write_n <= ~wr;
		host_read_n <= wr & ~both;
	endtask
	// The idle gap is well above the two-clock minimum between accesses.
	task automatic finish_access;
		@(posedge clk_sys);
		host_select_n <= 1'b1;
		host_read_n <= 1'b1;
		host_write_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic host_write(input logic [8:0] a, input logic [7:0] d);
		int c0;
		logic upd;
		c0 = n_commit;
		upd = a[8] && (a[7:2] != bhsp_pkg::QUEUE_TX_INDEX);
		start(1'b1, 1'($urandom_range(1)), a, d);
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		check("oe_write", 32'h0, {31'h0, host_byte_oe});
		finish_access;
		wshadow = merge(wshadow, a[1:0], d);
		check("commit_count", 32'(c0 + int'(upd)), 32'(n_commit));
		if (upd) begin
			check("commit_index", {26'h0, a[7:2]}, {26'h0, seen_idx});
			check("commit_word", wshadow, seen_data);
		end
	endtask
	// One extended read steps through all four lanes starting at the addressed one.
	task automatic host_read(input logic [8:0] a, input logic [31:0] exp);
		int r0;
		logic upd;
		r0 = n_rdreq;
		upd = a[8] && (a[7:2] != bhsp_pkg::QUEUE_RX_INDEX);
		start(1'b0, 1'b0, a, 8'h00);
		repeat (10) @(posedge clk_sys);
		if (a[8]) rshadow = exp;
		for (int l = 0; l < 4; l++) begin
			@(posedge clk_sys);
			host_addr[1:0] <= 2'(l + a[1:0]);
			@(negedge clk_sys);
			check("read_byte", {24'h0, lane_of(rshadow, 2'(l + a[1:0]))}, {24'h0, host_byte_out});
			check("oe_read", 32'h1, {31'h0, host_byte_oe});
		end
		finish_access;
		check("rd_req_count", 32'(r0 + int'(upd)), 32'(n_rdreq));
		if (upd) check("rd_req_index", {26'h0, a[7:2]}, {26'h0, seen_rd_idx});
		@(negedge clk_sys);
		check("oe_idle", 32'h0, {31'h0, host_byte_oe});
	endtask

	// ****************************************************************
	// Main sequence, watchdog and verdict
	// ****************************************************************
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk_sys);
		n_errors++;
		end_sim();
	end
	initial begin
		logic [5:0] idx;
		int n;
		void'($urandom(94));
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (6) @(posedge clk_sys);
		host_read({1'b0, 8'($urandom)}, 32'h0);
		for (int k = 0; k < 30; k++) begin
			idx = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($urandom);
			if (idx == bhsp_pkg::QUEUE_TX_INDEX || idx == bhsp_pkg::QUEUE_RX_INDEX) idx = 6'h22;
			n = $urandom_range(3);
			for (int j = 0; j < n; j++) host_write({1'b0, 8'($urandom)}, 8'($urandom));
			host_write({1'b1, idx, 2'($urandom)}, 8'($urandom));
			host_read({1'b1, idx, 2'($urandom)}, wshadow);
			host_read({1'b0, 6'($urandom), 2'($urandom)}, wshadow);
		end
		// Quadlet transfers with update raised by the byte lane alone, as outside logic would do it.
		for (int l = 0; l < 4; l++) host_write({l == 3, 6'h10, 2'(l)}, 8'($urandom));
		host_read({1'b1, 6'h10, 2'h0}, wshadow);
		for (int p = 0; p < 2; p++) begin
			for (int l = 0; l < 4; l++) begin
				host_write({l == 3, bhsp_pkg::QUEUE_TX_INDEX, 2'(l)}, 8'($urandom));
			end
			check("tx_count", 32'(p + 1), 32'(tx_count));
			check("tx_word", wshadow, tx_last);
			host_read({1'b1, bhsp_pkg::QUEUE_RX_INDEX, 2'h0}, RX_BASE + 32'(p));
		end
		end_sim();
	end
endmodule
